// [rtl/csq_charger_top.sv]
// Charger phase sequencer, status LEDs and setup register with its serial port.
`timescale 1ns/1ps
// Function
// - Slave logic runs on incoming bus clock.
// - Master makes start and stop; bus state follows.
// - Repeated start behaves as first start.
// - Eight bits MSB first, ninth clock acknowledges.
// - Seven address bits then direction bit.
// - Answer only the fixed bus address.
// - Index byte then data byte stored there.
// - Index and data pairs repeat until stop.
// - Adapter wins when both supplies present.
// - Below full-rate threshold: prequal current, 001.
// - Threshold reached: constant current, code 010.
// - Termination voltage reached: constant voltage, 011.
// - End-of-charge: timed top-off, 111, then complete.
// - Bit 0 selects 5 or 10 percent.
// - Complete stays off, 101, recharge resumes CC.
// - Green blinks in CV, steady when full.
// - No external power: both LEDs off.
// - Error: red off, green blinks.
// - Enable bit 1 suspends and resumes charging.
// - Disabled charger reports code 000, except 100 on a fault and, when already complete, 101 until recharge, then 010 for one cycle.
module csq_charger_top #(
	parameter int TICK_CYCLES      = csq_pkg::TICK_CYCLES_DEF,
	parameter int BLINK_HALF_TICKS = csq_pkg::BLINK_HALF_TICKS_DEF,
	parameter int TOPOFF_TICKS     = csq_pkg::TOPOFF_TICKS_DEF
) (
	// Core clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Serial port
	input  wire logic               scl_clk,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	// Supplies, comparators and faults from the analog section
	input  wire logic               adapter_present,
	input  wire logic               usb_present,
	input  wire csq_pkg::csq_sense_t sense,
	input  wire logic               batt_temp_fault,
	input  wire logic               thermal_shutdown,
	// Phase code
	output logic                    phase_code_bit2,
	output logic                    phase_code_bit1,
	output logic                    phase_code_bit0,
	// LEDs
	output logic                    red_led_pin,
	output logic                    green_led_pin,
	// Power path and charge control
	output logic                    src_adapter_sel,
	output logic                    src_usb_sel,
	output logic                    charge_on,
	output logic                    cv_regulate,
	output logic                    prequal_tenth,
	output logic                    prequal_usb_fixed,
	output logic [3:0]              icc_code,
	output logic [1:0]              vterm_code,
	output logic                    eoc_tenth
);
	import csq_pkg::*;

	logic       adapter_s, usb_s, temp_s, therm_s;
	csq_sense_t sense_s;
	logic       ext, err;
	csq_wr_t    wr;
	logic       wr_tog, wr_tog_s, wr_tog_d_reg;
	logic       wr_evt;
	csq_setup_t setup_reg, setup_next;

	logic [31:0] tick_cnt_reg, tick_cnt_next;
	logic        tick_reg, tick_next;
	logic [31:0] blink_cnt_reg, blink_cnt_next;
	logic        blink_reg, blink_next;
	logic [31:0] topoff_cnt_reg, topoff_cnt_next;
	logic        topoff_last;

	csq_phase_t state_reg, state_next;
	logic [2:0] phase_reg, phase_next;
	logic       red_reg, red_next;
	logic       green_reg, green_next;
	logic       src_ad_reg, src_ad_next;
	logic       src_usb_reg, src_usb_next;
	logic       chg_reg, chg_next;
	logic       cv_reg, cv_next;
	logic       pq_ad_reg, pq_ad_next;
	logic       pq_usb_reg, pq_usb_next;

	// Pins and the write toggle cross into the core clock domain.
	csq_sync #(.W(9)) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   ({adapter_present, usb_present, sense, batt_temp_fault, thermal_shutdown, wr_tog}),
		.q   ({adapter_s, usb_s, sense_s, temp_s, therm_s, wr_tog_s})
	);

	csq_i2c_slave u_port (
		.rst         (rst),
		.scl_clk     (scl_clk),
		.sda_in      (sda_in),
		.sda_out     (sda_out),
		.sda_oe      (sda_oe),
		.setup_byte  (setup_reg),
		.status_byte ({STATUS_PAD, phase_reg}),
		.wr          (wr),
		.wr_tog      (wr_tog)
	);

	assign ext    = adapter_s | usb_s;
	assign err    = temp_s | therm_s;
	// The written pair stays put for a whole byte time after the toggle, so it is read directly.
	assign wr_evt = wr_tog_s != wr_tog_d_reg;

	always_comb begin
		setup_next = setup_reg;
		if (wr_evt && wr.idx == IDX_SETUP) begin
			setup_next = wr.data;
		end
	end

	// Free-running prescaler: one millisecond tick and blink phase; the top-off count runs only in top-off.
	assign topoff_last = topoff_cnt_reg == 32'(TOPOFF_TICKS - 1);

	always_comb begin
		tick_next      = tick_cnt_reg == 32'(TICK_CYCLES - 1);
		tick_cnt_next  = tick_next ? '0 : tick_cnt_reg + 32'h1;
		blink_cnt_next = blink_cnt_reg;
		blink_next     = blink_reg;
		if (tick_reg) begin
			if (blink_cnt_reg == 32'(BLINK_HALF_TICKS - 1)) begin
				blink_cnt_next = '0;
				blink_next     = ~blink_reg;
			end else begin
				blink_cnt_next = blink_cnt_reg + 32'h1;
			end
		end
		topoff_cnt_next = '0;
		if (state_reg == CH_TOPOFF) begin
			topoff_cnt_next = topoff_cnt_reg + {31'h0, tick_reg};
		end
	end

	// Phase sequencer: loss of supply and faults override the charge flow, and so does disable except in the complete state.
	always_comb begin
		state_next = state_reg;
		if (!ext) begin
			state_next = CH_OFF;
		end else if (err) begin
			state_next = CH_ERR;
		end else if (!setup_reg.enable && state_reg != CH_DONE) begin
			state_next = CH_OFF;
		end else begin
			unique case (state_reg)
				CH_OFF, CH_ERR: begin
					state_next = sense_s.below_fullrate ? CH_PREQ : CH_CC;
				end
				CH_PREQ: begin
					if (!sense_s.below_fullrate) state_next = CH_CC;
				end
				CH_CC: begin
					if (sense_s.at_vterm) state_next = CH_CV;
				end
				CH_CV: begin
					if (sense_s.below_eoc) state_next = CH_TOPOFF;
				end
				CH_TOPOFF: begin
					if (tick_reg && topoff_last) state_next = CH_DONE;
				end
				CH_DONE: begin
					if (sense_s.below_restart) state_next = CH_CC;
				end
			endcase
		end
	end

	// Registered outputs derived from the current phase and the supplies.
	always_comb begin
		unique case (state_reg)
			CH_OFF:    phase_next = PH_OFF;
			CH_PREQ:   phase_next = PH_PREQ;
			CH_CC:     phase_next = PH_CC;
			CH_CV:     phase_next = PH_CV;
			CH_TOPOFF: phase_next = PH_TOPOFF;
			CH_DONE:   phase_next = PH_DONE;
			CH_ERR:    phase_next = PH_ERR;
		endcase
		chg_next     = state_reg inside {CH_PREQ, CH_CC, CH_CV, CH_TOPOFF};
		cv_next      = state_reg inside {CH_CV, CH_TOPOFF};
		pq_ad_next   = state_reg == CH_PREQ && adapter_s;
		pq_usb_next  = state_reg == CH_PREQ && !adapter_s;
		src_ad_next  = adapter_s;
		src_usb_next = usb_s && !adapter_s;
		red_next     = ext && state_reg inside {CH_PREQ, CH_CC, CH_CV, CH_TOPOFF, CH_DONE};
		unique case (state_reg)
			CH_CV, CH_ERR:     green_next = ext && blink_reg;
			CH_TOPOFF, CH_DONE: green_next = ext;
			default:           green_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_tog_d_reg   <= 1'b0;
			setup_reg      <= SETUP_RST;
			tick_cnt_reg   <= '0;
			tick_reg       <= 1'b0;
			blink_cnt_reg  <= '0;
			blink_reg      <= 1'b0;
			topoff_cnt_reg <= '0;
			state_reg      <= CH_OFF;
			phase_reg      <= PH_OFF;
			red_reg        <= 1'b0;
			green_reg      <= 1'b0;
			src_ad_reg     <= 1'b0;
			src_usb_reg    <= 1'b0;
			chg_reg        <= 1'b0;
			cv_reg         <= 1'b0;
			pq_ad_reg      <= 1'b0;
			pq_usb_reg     <= 1'b0;
		end else begin
			wr_tog_d_reg   <= wr_tog_s;
			setup_reg      <= setup_next;
			tick_cnt_reg   <= tick_cnt_next;
			tick_reg       <= tick_next;
			blink_cnt_reg  <= blink_cnt_next;
			blink_reg      <= blink_next;
			topoff_cnt_reg <= topoff_cnt_next;
			state_reg      <= state_next;
			phase_reg      <= phase_next;
			red_reg        <= red_next;
			green_reg      <= green_next;
			src_ad_reg     <= src_ad_next;
			src_usb_reg    <= src_usb_next;
			chg_reg        <= chg_next;
			cv_reg         <= cv_next;
			pq_ad_reg      <= pq_ad_next;
			pq_usb_reg     <= pq_usb_next;
		end
	end

	assign phase_code_bit2   = phase_reg[2];
	assign phase_code_bit1   = phase_reg[1];
	assign phase_code_bit0   = phase_reg[0];
	assign red_led_pin       = red_reg;
	assign green_led_pin     = green_reg;
	assign src_adapter_sel   = src_ad_reg;
	assign src_usb_sel       = src_usb_reg;
	assign charge_on         = chg_reg;
	assign cv_regulate       = cv_reg;
	assign prequal_tenth     = pq_ad_reg;
	assign prequal_usb_fixed = pq_usb_reg;
	assign icc_code          = setup_reg.icc;
	assign vterm_code        = setup_reg.vterm;
	assign eoc_tenth         = setup_reg.eoc_tenth;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_setup_write: assert property (wr_evt && wr.idx == IDX_SETUP |=> setup_reg == $past(wr.data))
		else $error("setup register missed a write");
	a_adapter_prio: assert property (adapter_s && usb_s |=> src_adapter_sel && !src_usb_sel)
		else $error("adapter not preferred over usb");
	a_prequal_code: assert property (state_reg == CH_PREQ |=> phase_reg == PH_PREQ && charge_on)
		else $error("prequal phase code wrong");
	a_cc_entry: assert property (state_reg == CH_PREQ && ext && !err && setup_reg.enable && !sense_s.below_fullrate |=> state_reg == CH_CC ##1 phase_reg == PH_CC)
		else $error("full rate not entered");
	a_cv_entry: assert property (state_reg == CH_CC && ext && !err && setup_reg.enable && sense_s.at_vterm |=> state_reg == CH_CV ##1 phase_reg == PH_CV)
		else $error("constant voltage not entered");
	a_topoff_end: assert property (state_reg == CH_TOPOFF && tick_reg && topoff_last && ext && !err && setup_reg.enable |=> state_reg == CH_DONE ##1 phase_reg == PH_DONE)
		else $error("top-off did not complete");
	a_done_hold: assert property (state_reg == CH_DONE && ext && !err && !sense_s.below_restart |=> state_reg == CH_DONE && !charge_on)
		else $error("complete state left early");
	a_leds_nopower: assert property (!ext |=> !red_led_pin && !green_led_pin)
		else $error("led lit without external power");
	a_error_leds: assert property (state_reg == CH_ERR && ext |=> !red_led_pin && green_led_pin == $past(blink_reg))
		else $error("error indication wrong");
	a_disable_off: assert property (ext && !err && !setup_reg.enable && state_reg != CH_DONE |=> state_reg == CH_OFF ##1 phase_reg == PH_OFF)
		else $error("disable did not stop charging");

	c_reach_cv: cover property (state_reg == CH_CC ##1 state_reg == CH_CV);
	c_reach_done: cover property (state_reg == CH_TOPOFF ##1 state_reg == CH_DONE);
	c_error: cover property (state_reg == CH_ERR);
	c_setup_write: cover property (wr_evt && wr.idx == IDX_SETUP);
endmodule

// [inc/csq_pkg.sv]
// Shared constants and types for the charger sequencer block.
package csq_pkg;
	// Core clock and derived timing.
	localparam int CLK_HZ               = 200_000_000;
	localparam int TICK_MS              = 1;
	localparam int MS_PER_S             = 1000;
	localparam int S_PER_MIN            = 60;
	localparam int TICK_CYCLES_DEF      = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int BLINK_PERIOD_MS      = 1000;
	localparam int BLINK_HALF_TICKS_DEF = BLINK_PERIOD_MS / 2 / TICK_MS;
	localparam int TOPOFF_MIN           = 21;
	localparam int TOPOFF_TICKS_DEF     = TOPOFF_MIN * S_PER_MIN * MS_PER_S / TICK_MS;

	// Serial port addressing and register map.
	localparam logic [6:0] DEV_ADDR    = 7'h60;
	localparam logic [7:0] IDX_SETUP   = 8'h01;
	localparam logic [7:0] IDX_STATUS  = 8'h02;
	localparam logic [7:0] SETUP_RST   = 8'h43;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam logic [4:0] STATUS_PAD  = 5'h00;
	localparam logic [2:0] BYTE_LAST   = 3'h7;
	localparam logic [2:0] BIT_FIRST   = 3'h1;

	// Phase codes reported on the status bits.
	localparam logic [2:0] PH_OFF    = 3'h0;
	localparam logic [2:0] PH_PREQ   = 3'h1;
	localparam logic [2:0] PH_CC     = 3'h2;
	localparam logic [2:0] PH_CV     = 3'h3;
	localparam logic [2:0] PH_ERR    = 3'h4;
	localparam logic [2:0] PH_DONE   = 3'h5;
	localparam logic [2:0] PH_TOPOFF = 3'h7;

	typedef struct packed {
		logic [1:0] vterm;
		logic [3:0] icc;
		logic       enable;
		logic       eoc_tenth;
	} csq_setup_t;

	typedef struct packed {
		logic below_fullrate;
		logic at_vterm;
		logic below_eoc;
		logic below_restart;
	} csq_sense_t;

	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] data;
	} csq_wr_t;

	typedef enum {
		CH_OFF,
		CH_PREQ,
		CH_CC,
		CH_CV,
		CH_TOPOFF,
		CH_DONE,
		CH_ERR
	} csq_phase_t;
endpackage

// [rtl/csq_sync.sv]
// Two-flop level synchroniser of configurable width.
`timescale 1ns/1ps
module csq_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= meta_next;
			q_reg    <= q_next;
		end
	end

	assign q = q_reg;
endmodule

// [rtl/csq_i2c_slave.sv]
// Serial slave port clocked by the incoming bus clock.
`timescale 1ns/1ps
module csq_i2c_slave (
	// Reset and bus clock
	input  wire logic             rst,
	input  wire logic             scl_clk,
	// Data pin
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe,
	// Register contents from the core domain
	input  wire logic [7:0]       setup_byte,
	input  wire logic [7:0]       status_byte,
	// Write event towards the core domain
	output csq_pkg::csq_wr_t      wr,
	output logic                  wr_tog
);
	import csq_pkg::*;

	typedef enum {
		B_IDLE,
		B_ADDR,
		B_ADDR_ACK,
		B_INDEX,
		B_INDEX_ACK,
		B_DATA,
		B_DATA_ACK,
		B_READ,
		B_READ_ACK
	} csq_bus_t;

	logic       start_tg_reg, start_tg_next;
	logic       stop_tg_reg, stop_tg_next;
	logic       start_ack_reg, stop_ack_reg;
	csq_bus_t   state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] idx_reg, idx_next;
	logic [7:0] rd_reg, rd_next;
	csq_wr_t    wr_reg, wr_next;
	logic       wr_tog_reg, wr_tog_next;
	logic       oe_reg, oe_next;
	logic [7:0] shifted;
	logic [7:0] rd_pick;
	logic [7:0] setup_s, status_s;

	// Conditions seen while the bus clock is high: falling data is a start, rising a stop.
	always_comb begin
		start_tg_next = scl_clk ? ~start_tg_reg : start_tg_reg;
		stop_tg_next  = scl_clk ? ~stop_tg_reg : stop_tg_reg;
	end

	always_ff @(negedge sda_in or posedge rst) begin
		if (rst) begin
			start_tg_reg <= 1'b0;
		end else begin
			start_tg_reg <= start_tg_next;
		end
	end

	always_ff @(posedge sda_in or posedge rst) begin
		if (rst) begin
			stop_tg_reg <= 1'b0;
		end else begin
			stop_tg_reg <= stop_tg_next;
		end
	end

	// Register contents are brought into the bus clock domain before they are shifted out.
	csq_sync #(.W(16)) u_rd_sync (
		.clk (scl_clk),
		.rst (rst),
		.d   ({setup_byte, status_byte}),
		.q   ({setup_s, status_s})
	);

	always_comb begin
		shifted = {sh_reg[6:0], sda_in};
		unique case (idx_reg)
			IDX_SETUP:  rd_pick = setup_s;
			IDX_STATUS: rd_pick = status_s;
			default:    rd_pick = UNMAPPED_RD;
		endcase
		state_next  = state_reg;
		cnt_next    = cnt_reg + 3'h1;
		sh_next     = shifted;
		idx_next    = idx_reg;
		rd_next     = rd_reg;
		wr_next     = wr_reg;
		wr_tog_next = wr_tog_reg;
		if (start_tg_reg != start_ack_reg) begin
			// A repeated start restarts the address phase like a first one.
			state_next = B_ADDR;
			cnt_next   = BIT_FIRST;
		end else if (stop_tg_reg != stop_ack_reg) begin
			state_next = B_IDLE;
		end else begin
			unique case (state_reg)
				B_IDLE: begin
					cnt_next = '0;
				end
				B_ADDR: begin
					if (cnt_reg == BYTE_LAST) begin
						state_next = (shifted[7:1] == DEV_ADDR) ? B_ADDR_ACK : B_IDLE;
					end
				end
				B_ADDR_ACK: begin
					cnt_next = '0;
					if (sh_reg[0]) begin
						state_next = B_READ;
						rd_next    = rd_pick;
					end else begin
						state_next = B_INDEX;
					end
				end
				B_INDEX: begin
					if (cnt_reg == BYTE_LAST) begin
						state_next = B_INDEX_ACK;
						idx_next   = shifted;
					end
				end
				B_INDEX_ACK: begin
					state_next = B_DATA;
					cnt_next   = '0;
				end
				B_DATA: begin
					if (cnt_reg == BYTE_LAST) begin
						state_next  = B_DATA_ACK;
						wr_next     = '{idx: idx_reg, data: shifted};
						wr_tog_next = ~wr_tog_reg;
					end
				end
				B_DATA_ACK: begin
					state_next = B_INDEX;
					cnt_next   = '0;
				end
				B_READ: begin
					rd_next = {rd_reg[6:0], 1'b0};
					if (cnt_reg == BYTE_LAST) begin
						state_next = B_READ_ACK;
					end
				end
				B_READ_ACK: begin
					cnt_next   = '0;
					state_next = sda_in ? B_IDLE : B_READ;
					rd_next    = rd_pick;
				end
			endcase
		end
	end

	// Data and acknowledge are changed on the falling bus clock only.
	always_comb begin
		unique case (state_reg)
			B_ADDR_ACK, B_INDEX_ACK, B_DATA_ACK: oe_next = 1'b1;
			B_READ:                              oe_next = ~rd_reg[7];
			default:                             oe_next = 1'b0;
		endcase
	end

	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			start_ack_reg <= 1'b0;
			stop_ack_reg  <= 1'b0;
			state_reg     <= B_IDLE;
			cnt_reg       <= '0;
			sh_reg        <= '0;
			idx_reg       <= '0;
			rd_reg        <= '0;
			wr_reg        <= '0;
			wr_tog_reg    <= 1'b0;
		end else begin
			start_ack_reg <= start_tg_reg;
			stop_ack_reg  <= stop_tg_reg;
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			sh_reg        <= sh_next;
			idx_reg       <= idx_next;
			rd_reg        <= rd_next;
			wr_reg        <= wr_next;
			wr_tog_reg    <= wr_tog_next;
		end
	end

	always_ff @(negedge scl_clk or posedge rst) begin
		if (rst) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= oe_next;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_reg;
	assign wr      = wr_reg;
	assign wr_tog  = wr_tog_reg;
endmodule

// [test/csq_i2c_master.sv]
// Bus master model that drives the serial clock and data lines.
`timescale 1ns/1ps
module csq_i2c_master #(
	parameter real HALF_NS = 7.5
) (
	// Bus lines
	output logic      scl_clk,
	output logic      sda_m,
	input  wire logic sda_in
);
	// The clock stands high between frames and the data line rests on its pull-up.
	initial begin
		scl_clk = 1'b1;
		sda_m = 1'b1;
	end

	// Serves as first start and as repeated start alike.
	task automatic start();
		sda_m = 1'b1;
		#HALF_NS scl_clk = 1'b1;
		#HALF_NS sda_m = 1'b0;
		#HALF_NS scl_clk = 1'b0;
	endtask

	task automatic stop();
		sda_m = 1'b0;
		#HALF_NS scl_clk = 1'b1;
		#HALF_NS sda_m = 1'b1;
		#HALF_NS;
	endtask

	// Data changes only while the clock is low; the bus level is taken at the rise.
	task automatic pulse(input logic b, output logic s);
		sda_m = b;
		#HALF_NS scl_clk = 1'b1;
		s = sda_in;
		#HALF_NS scl_clk = 1'b0;
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(d[i], s);
		pulse(1'b1, ack);
	endtask

	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
		pulse(nack, s);
	endtask
endmodule

// [test/test_csq_charger_top.sv]
// Self-checking testbench for the charger sequencer block.
`timescale 1ns/1ps
module test_csq_charger_top;
	import csq_pkg::*;
	localparam int TK = 10;
	localparam int BH = 4;
	localparam int TO = 20;
	logic       clk, rst, scl_clk, sda_m, sda_in, sda_out, sda_oe;
	logic       adapter_present, usb_present, batt_temp_fault, thermal_shutdown;
	csq_sense_t sense;
	logic       phase_code_bit2, phase_code_bit1, phase_code_bit0;
	logic       red_led_pin, green_led_pin, src_adapter_sel, src_usb_sel;
	logic       charge_on, cv_regulate, prequal_tenth, prequal_usb_fixed, eoc_tenth;
	logic [3:0] icc_code;
	logic [1:0] vterm_code;
	logic [2:0] ph;
	logic [7:0] rd;
	int         fail_count = 0;
	int         cmp_count = 0;

	// Open-drain data line with pull-up.
	assign sda_in = sda_m & ~sda_oe;
	assign ph = {phase_code_bit2, phase_code_bit1, phase_code_bit0};

	csq_charger_top #(.TICK_CYCLES(TK), .BLINK_HALF_TICKS(BH), .TOPOFF_TICKS(TO)) DUT (
		.clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .adapter_present(adapter_present), .usb_present(usb_present),
		.sense(sense), .batt_temp_fault(batt_temp_fault), .thermal_shutdown(thermal_shutdown),
		.phase_code_bit2(phase_code_bit2), .phase_code_bit1(phase_code_bit1),
		.phase_code_bit0(phase_code_bit0), .red_led_pin(red_led_pin),
		.green_led_pin(green_led_pin), .src_adapter_sel(src_adapter_sel),
		.src_usb_sel(src_usb_sel), .charge_on(charge_on), .cv_regulate(cv_regulate),
		.prequal_tenth(prequal_tenth), .prequal_usb_fixed(prequal_usb_fixed),
		.icc_code(icc_code), .vterm_code(vterm_code), .eoc_tenth(eoc_tenth));

	csq_i2c_master MST (.scl_clk(scl_clk), .sda_m(sda_m), .sda_in(sda_in));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Waits a bounded time for a phase code; a miss ends the run.
	task automatic wait_ph(input logic [2:0] exp);
		int n;
		n = 0;
		while (ph !== exp && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk({5'h00, ph}, {5'h00, exp});
		if (ph !== exp) stop_test();
		repeat (2) @(posedge clk);
	endtask

	// Any window of one full blink period holds exactly half a period of lit cycles.
	task automatic blink();
		int h;
		h = 0;
		repeat (2 * BH * TK) begin
			@(posedge clk);
			if (green_led_pin === 1'b1) h++;
		end
		chk(h[7:0], 8'(BH * TK));
	endtask

	task automatic bwr(input logic [7:0] d, input logic exp_ack);
		logic a;
		MST.put_byte(d, a);
		chk({7'h00, a}, {7'h00, exp_ack});
	endtask

	task automatic reg_read(input logic [7:0] idx, output logic [7:0] d);
		MST.start();
		bwr({7'h60, 1'b0}, 1'b0);
		bwr(idx, 1'b0);
		MST.start();
		bwr({7'h60, 1'b1}, 1'b0);
		MST.get_byte(1'b1, d);
		MST.stop();
	endtask

	task automatic wr_setup(input logic [7:0] d);
		MST.start();
		bwr({7'h60, 1'b0}, 1'b0);
		bwr(8'h01, 1'b0);
		bwr(d, 1'b0);
		MST.stop();
		repeat (10) @(posedge clk);
	endtask

	task automatic t_reset();
		chk({1'b0, icc_code, vterm_code, eoc_tenth}, 8'h03);
		chk({3'h0, ph, red_led_pin, green_led_pin}, 8'h00);
		reg_read(8'h01, rd);
		chk(rd, 8'h43);
		$display("test reset done");
	endtask

	task automatic t_bus();
		MST.start();
		bwr({7'h60, 1'b0}, 1'b0);
		bwr(8'h05, 1'b0);
		bwr(8'hff, 1'b0);
		bwr(8'h01, 1'b0);
		bwr(8'h9e, 1'b0);
		MST.stop();
		repeat (10) @(posedge clk);
		chk({1'b0, icc_code, vterm_code, eoc_tenth}, 8'h3c);
		reg_read(8'h01, rd);
		chk(rd, 8'h9e);
		reg_read(8'h07, rd);
		chk(rd, 8'h00);
		MST.start();
		bwr({7'h61, 1'b0}, 1'b1);
		bwr(8'h01, 1'b1);
		bwr(8'h00, 1'b1);
		MST.stop();
		repeat (10) @(posedge clk);
		chk({1'b0, icc_code, vterm_code, eoc_tenth}, 8'h3c);
		$display("test bus done");
	endtask

	task automatic t_charge();
		@(posedge clk) begin
			adapter_present <= 1'b1;
			usb_present <= 1'b1;
			sense <= 4'b1000;
		end
		wait_ph(3'b001);
		chk({4'h0, src_adapter_sel, src_usb_sel, prequal_tenth, prequal_usb_fixed}, 8'h0a);
		chk({6'h0, red_led_pin, green_led_pin}, 8'h02);
		@(posedge clk) sense <= 4'b0000;
		wait_ph(3'b010);
		chk({6'h0, charge_on, cv_regulate}, 8'h02);
		@(posedge clk) sense <= 4'b0100;
		wait_ph(3'b011);
		chk({6'h0, charge_on, cv_regulate}, 8'h03);
		blink();
		@(posedge clk) sense <= 4'b0110;
		wait_ph(3'b111);
		chk({6'h0, red_led_pin, green_led_pin}, 8'h03);
		repeat (TO * TK - 50) @(posedge clk);
		chk({5'h00, ph}, 8'h07);
		wait_ph(3'b101);
		chk({5'h0, charge_on, red_led_pin, green_led_pin}, 8'h03);
		wr_setup(8'h9c);
		repeat (20) @(posedge clk);
		chk({5'h00, ph}, 8'h05);
		wr_setup(8'h9e);
		@(posedge clk) sense <= 4'b0001;
		wait_ph(3'b010);
		@(posedge clk) sense <= 4'b0000;
		wr_setup(8'h9c);
		wait_ph(3'b000);
		chk({7'h0, charge_on}, 8'h00);
		wr_setup(8'h9e);
		wait_ph(3'b010);
		$display("test charge done");
	endtask

	task automatic t_fault();
		@(posedge clk) thermal_shutdown <= 1'b1;
		wait_ph(3'b100);
		chk({7'h0, red_led_pin}, 8'h00);
		blink();
		@(posedge clk) begin
			thermal_shutdown <= 1'b0;
			batt_temp_fault <= 1'b1;
		end
		repeat (10) @(posedge clk);
		wait_ph(3'b100);
		@(posedge clk) batt_temp_fault <= 1'b0;
		wait_ph(3'b010);
		@(posedge clk) begin
			adapter_present <= 1'b0;
			sense <= 4'b1000;
		end
		// Full-rate charging never falls back to prequal by itself, so cycle the enable bit.
		wr_setup(8'h9c);
		wait_ph(3'b000);
		wr_setup(8'h9e);
		wait_ph(3'b001);
		chk({4'h0, src_adapter_sel, src_usb_sel, prequal_tenth, prequal_usb_fixed}, 8'h05);
		@(posedge clk) usb_present <= 1'b0;
		wait_ph(3'b000);
		chk({6'h0, red_led_pin, green_led_pin}, 8'h00);
		$display("test fault done");
	endtask

	initial begin
		rst = 1'b1;
		adapter_present = 1'b0;
		usb_present = 1'b0;
		sense = '0;
		batt_temp_fault = 1'b0;
		thermal_shutdown = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		t_reset();
		t_bus();
		t_charge();
		t_fault();
		stop_test();
	end
endmodule
